/* hdl/sfr_flags_cfg.svh */
// Offsets, field positions, reset values and timing counts of the flag bank
// Assumes inclusion by bare name from files that need the register map
`ifndef SFR_FLAGS_CFG_SVH
`define SFR_FLAGS_CFG_SVH

// Register indices; the byte address is four times the index
`define SFR_IDX_FLAGS_ONE   4'h2
`define SFR_IDX_FLAGS_TWO   4'h3
`define SFR_IDX_ENABLES_TWO 4'h5

// Flag register 1 fields
`define F1_WDT_POS  0
`define F1_OF_POS   1
`define F1_P0_POS   2
`define F1_P1_POS   3
`define F1_NMI_POS  4
`define F1_RESET    5'h02

// Flag register 2 fields
`define F2_RX_POS   0
`define F2_TX_POS   1
`define F2_BT_POS   7
`define F2_RESET    3'h2

// Module enable register 2 fields
`define ME2_RX_POS  0
`define ME2_TX_POS  1
`define ME2_RESET   2'h0

// Cycles from an accepted address phase to hreadyout high
`define BUS_WAIT_CYCLES 1

`endif

/* hdl/sfr_flags_pkg.sv */
// Types shared by the flag bank and its testbench
// Assumes sfr_flags_cfg.svh holds the numeric constants
package sfr_flags_pkg;

  typedef struct packed {
    logic pin_nonmask_flag;
    logic port_bit1_flag;
    logic port_bit0_flag;
    logic osc_fault_flag;
    logic watchdog_flag;
  } flags_one_t;

  typedef struct packed {
    logic basic_timer_flag;
    logic serial_tx_flag;
    logic serial_rx_flag;
  } flags_two_t;

  typedef struct packed {
    logic serial_tx_enable;
    logic serial_rx_enable;
  } enables_two_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_F1    = 2'b01,
    SEL_F2    = 2'b10,
    SEL_ME2   = 2'b11
  } reg_sel_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_state_t;

endpackage : sfr_flags_pkg

/* hdl/pin_event_sync.sv */
// Two-stage synchroniser and edge detector for asynchronous event pins
// Assumes pins are asynchronous to hclk; edge select comes from hclk logic
`timescale 1ns/1ns
`default_nettype none

module pin_event_sync
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] fall_sel,
  output logic      [WIDTH-1:0] event_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_event_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else if (ce)
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // One-cycle pulse on the selected edge
  assign event_o = (sync_r ^ prev_r) & ((fall_sel & prev_r) | (~fall_sel & sync_r));

endmodule : pin_event_sync

`default_nettype wire

/* hdl/sfr_flags.sv */
// Special function flag and module enable registers on an AHB-Lite slave
// Assumes one master, single word transfers, event inputs from hclk logic
// except the three pins, which are synchronised here
// Function
// - Flag and enable bits sit in the lowest byte of word registers at indices 2, 3 and 5.
// - Unassigned bit positions have no flip-flop behind them.
// - Watchdog flag sets on counter overflow or security key violation.
// - Watchdog flag clears on power-on or pin reset.
// - Oscillator-fault flag sets on oscillator fault; software reads and writes it.
// - Pin non-maskable flag sets on the configured edge at the pin.
// - Port bit 0 flag sets on its event, clears at reset, is writable.
// - Port bit 1 flag sets on its event, pin shared with timer receive.
// - Serial receive flag clears at reset, sets on a received character.
// - Serial transmit flag resets to 1 and is software writable.
// - Basic-timer flag is read-write with no meaningful reset value.
// - Enable register holds transmit and receive enables, read-write, reset 0.
// - Flag register 2 holds timer at bit 7, transmit bit 1, receive bit 0.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sfr_flags_cfg.svh"

module sfr_flags
  import sfr_flags_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic      [31:0]  hrdata,
  input  wire logic         wdt_overflow,
  input  wire logic         wdt_key_violation,
  input  wire logic         osc_fault,
  input  wire logic         nmi_pin,
  input  wire logic         nmi_falling,
  input  wire logic         port0_pin,
  input  wire logic         port1_pin,
  input  wire logic         serial_rx_done,
  input  wire logic         serial_tx_ready,
  input  wire logic         basic_timer_tick,
  output flags_one_t        flags_one,
  output flags_two_t        flags_two,
  output enables_two_t      enables_two
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  flags_one_t   flags_one_r;
  flags_one_t   flags_one_nxt;
  flags_two_t   flags_two_r;
  flags_two_t   flags_two_nxt;
  enables_two_t enables_two_r;
  enables_two_t enables_two_nxt;
  bus_state_t   state_r;
  reg_sel_t     sel_r;
  logic         wr_r;
  logic         hreadyout_r;
  logic [31:0]  hrdata_r;
  logic         take;
  logic         commit;
  logic         wr_commit;
  logic [2:0]   pin_evt;
  logic         nmi_evt;
  logic         port0_evt;
  logic         port1_evt;
  logic [7:0]   wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte address of a register index
  function automatic logic [31:0] idx_addr(input logic [3:0] idx);
    idx_addr = {26'h0, idx, 2'b00};
  endfunction : idx_addr

  // Word decode; low two address bits are ignored, unmapped gives SEL_NONE
  function automatic reg_sel_t decode(input logic [31:0] addr);
    logic [31:0] word;
    word = {addr[31:2], 2'b00};
    if (word == idx_addr(`SFR_IDX_FLAGS_ONE))
      decode = SEL_F1;
    else if (word == idx_addr(`SFR_IDX_FLAGS_TWO))
      decode = SEL_F2;
    else if (word == idx_addr(`SFR_IDX_ENABLES_TWO))
      decode = SEL_ME2;
    else
      decode = SEL_NONE;
  endfunction : decode

  // Packs a register into its byte; unassigned positions read 0
  function automatic logic [7:0] read_byte(input reg_sel_t sel,
                                           input flags_one_t f1,
                                           input flags_two_t f2,
                                           input enables_two_t me);
    logic [7:0] b;
    b = 8'h00;
    case (sel)
      SEL_F1:
      begin
        b[`F1_WDT_POS] = f1.watchdog_flag;
        b[`F1_OF_POS]  = f1.osc_fault_flag;
        b[`F1_P0_POS]  = f1.port_bit0_flag;
        b[`F1_P1_POS]  = f1.port_bit1_flag;
        b[`F1_NMI_POS] = f1.pin_nonmask_flag;
      end
      SEL_F2:
      begin
        b[`F2_RX_POS] = f2.serial_rx_flag;
        b[`F2_TX_POS] = f2.serial_tx_flag;
        b[`F2_BT_POS] = f2.basic_timer_flag;
      end
      SEL_ME2:
      begin
        b[`ME2_RX_POS] = me.serial_rx_enable;
        b[`ME2_TX_POS] = me.serial_tx_enable;
      end
      default:
      begin
        b = 8'h00;
      end
    endcase
    read_byte = b;
  endfunction : read_byte

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Port pins detect rising edges; pin interrupt edge is software selected
  pin_event_sync #(
    .WIDTH    (3)
  ) u_pins (
    .clk      (hclk),
    .rst_n    (hresetn),
    .ce       (ce),
    .pin_in   ({port1_pin, port0_pin, nmi_pin}),
    .fall_sel ({1'b0, 1'b0, nmi_falling}),
    .event_o  (pin_evt)
  );

  assign nmi_evt   = pin_evt[0];
  assign port0_evt = pin_evt[1];
  assign port1_evt = pin_evt[2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // hsize is not checked: only whole-word transfers are expected
  assign take      = ce && hsel && htrans[1] && hready && (state_r == BUS_IDLE);
  assign commit    = ce && (state_r == BUS_WAIT);
  assign wr_commit = commit && wr_r;
  assign wbyte     = hwdata[7:0];

  // One wait state lets write data arrive before it is stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r     <= BUS_IDLE;
      sel_r       <= SEL_NONE;
      wr_r        <= 1'b0;
      hreadyout_r <= 1'b1;
    end
    else if (ce)
    begin
      case (state_r)
        BUS_IDLE:
        begin
          if (take)
          begin
            state_r     <= BUS_WAIT;
            sel_r       <= decode(haddr);
            wr_r        <= hwrite;
            hreadyout_r <= 1'b0;
          end
        end
        BUS_WAIT:
        begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
        default:
        begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  // Read data is held until the next read completes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (commit && !wr_r)
      hrdata_r <= {24'h00_0000, read_byte(sel_r, flags_one_r, flags_two_r, enables_two_r)};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the flags; set terms are ORed last so they win

  always_comb
  begin
    flags_one_nxt = flags_one_r;
    if (wr_commit && sel_r == SEL_F1)
    begin
      flags_one_nxt.watchdog_flag    = wbyte[`F1_WDT_POS];
      flags_one_nxt.osc_fault_flag   = wbyte[`F1_OF_POS];
      flags_one_nxt.port_bit0_flag   = wbyte[`F1_P0_POS];
      flags_one_nxt.port_bit1_flag   = wbyte[`F1_P1_POS];
      flags_one_nxt.pin_nonmask_flag = wbyte[`F1_NMI_POS];
    end
    if (wdt_overflow || wdt_key_violation)
      flags_one_nxt.watchdog_flag = 1'b1;
    if (osc_fault)
      flags_one_nxt.osc_fault_flag = 1'b1;
    if (port0_evt)
      flags_one_nxt.port_bit0_flag = 1'b1;
    if (port1_evt)
      flags_one_nxt.port_bit1_flag = 1'b1;
    if (nmi_evt)
      flags_one_nxt.pin_nonmask_flag = 1'b1;
  end

  always_comb
  begin
    flags_two_nxt = flags_two_r;
    if (wr_commit && sel_r == SEL_F2)
    begin
      flags_two_nxt.serial_rx_flag   = wbyte[`F2_RX_POS];
      flags_two_nxt.serial_tx_flag   = wbyte[`F2_TX_POS];
      flags_two_nxt.basic_timer_flag = wbyte[`F2_BT_POS];
    end
    if (serial_rx_done)
      flags_two_nxt.serial_rx_flag = 1'b1;
    if (serial_tx_ready)
      flags_two_nxt.serial_tx_flag = 1'b1;
    if (basic_timer_tick)
      flags_two_nxt.basic_timer_flag = 1'b1;
  end

  always_comb
  begin
    enables_two_nxt = enables_two_r;
    if (wr_commit && sel_r == SEL_ME2)
    begin
      enables_two_nxt.serial_rx_enable = wbyte[`ME2_RX_POS];
      enables_two_nxt.serial_tx_enable = wbyte[`ME2_TX_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage; only assigned bits have flip-flops

  // Reset here is power-on or pin reset, which also clears the watchdog flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_one_r <= flags_one_t'(`F1_RESET);
    else if (ce)
      flags_one_r <= flags_one_nxt;
  end

  // Timer flag has no defined reset value; 0 is used for determinism
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_two_r <= flags_two_t'(`F2_RESET);
    else if (ce)
      flags_two_r <= flags_two_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enables_two_r <= enables_two_t'(`ME2_RESET);
    else if (ce)
      enables_two_r <= enables_two_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout   = hreadyout_r;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_r;
  assign flags_one   = flags_one_r;
  assign flags_two   = flags_two_r;
  assign enables_two = enables_two_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_take_write(reg_sel_t s);
    take && hwrite && decode(haddr) == s;
  endsequence

  sequence s_take_read(reg_sel_t s);
    take && !hwrite && decode(haddr) == s;
  endsequence

  property p_wdt_set;
    ce && (wdt_overflow || wdt_key_violation) |=> flags_one_r.watchdog_flag;
  endproperty
  a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set");

  property p_of_set;
    ce && osc_fault |=> flags_one_r.osc_fault_flag;
  endproperty
  a_of_set: assert property (p_of_set) else $error("oscillator flag not set");

  property p_nmi_pin;
    ce && nmi_evt |=> flags_one_r.pin_nonmask_flag;
  endproperty
  a_nmi_pin: assert property (p_nmi_pin) else $error("pin flag not set");

  property p_port_flags;
    ce && (port0_evt || port1_evt)
      |=> (flags_one_r.port_bit0_flag || !$past(port0_evt))
       && (flags_one_r.port_bit1_flag || !$past(port1_evt));
  endproperty
  a_port_flags: assert property (p_port_flags) else $error("port flag not set");

  property p_rx_wins;
    s_take_write(SEL_F2) ##1 (ce && serial_rx_done && !wbyte[`F2_RX_POS])
      |=> flags_two_r.serial_rx_flag;
  endproperty
  a_rx_wins: assert property (p_rx_wins) else $error("write beat hardware set");

  property p_f2_write;
    s_take_write(SEL_F2) ##1 (ce && !serial_rx_done && !serial_tx_ready && !basic_timer_tick)
      |=> flags_two_r == {$past(wbyte[`F2_BT_POS]), $past(wbyte[`F2_TX_POS]), $past(wbyte[`F2_RX_POS])};
  endproperty
  a_f2_write: assert property (p_f2_write) else $error("flag register 2 write wrong");

  property p_me2_write;
    s_take_write(SEL_ME2) ##1 ce
      |=> enables_two_r == {$past(wbyte[`ME2_TX_POS]), $past(wbyte[`ME2_RX_POS])};
  endproperty
  a_me2_write: assert property (p_me2_write) else $error("enable write lost");

  property p_f1_read_zero;
    s_take_read(SEL_F1) ##1 ce |=> hreadyout_r && hrdata_r[31:5] == 27'h0;
  endproperty
  a_f1_read_zero: assert property (p_f1_read_zero) else $error("unused bits not zero");

  property p_unmapped_zero;
    s_take_read(SEL_NONE) ##1 ce |=> hrdata_r == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_tx_read;
    s_take_read(SEL_F2) ##1 (ce && flags_two_r.serial_tx_flag) |=> hrdata_r[`F2_TX_POS];
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("tx flag misread");

  property p_timer_set;
    ce && basic_timer_tick |=> flags_two_r.basic_timer_flag;
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag not set");

  property p_rx_set;
    ce && serial_rx_done |=> flags_two_r.serial_rx_flag;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive flag not set");

  property p_no_set_no_rise;
    ce && !wr_commit && !osc_fault |=> !$rose(flags_one_r.osc_fault_flag);
  endproperty
  a_no_set_no_rise: assert property (p_no_set_no_rise) else $error("flag rose unprompted");

endmodule : sfr_flags

`default_nettype wire

/* testbench/ahb_master_model.sv */
// AHB-Lite master standing in for CPU software on the register bus
// Assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ns
`default_nettype none

module ahb_master_model
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One single word transfer; waits last until hready, only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do
    begin
      @(posedge hclk);
    end
    while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge hclk);
    end
    while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : ahb_master_model
`default_nettype wire

/* testbench/tb_special_function_flag_regs.sv */
// Self-checking bench for the special function flag bank
// Assumes the register map header and the AHB-Lite master model
`timescale 1ns/1ns
`default_nettype none
`include "sfr_flags_cfg.svh"

module tb_special_function_flag_regs
  import sfr_flags_pkg::*;
;
  localparam logic [31:0] A_F1  = {26'h0, `SFR_IDX_FLAGS_ONE, 2'b00};
  localparam logic [31:0] A_F2  = {26'h0, `SFR_IDX_FLAGS_TWO, 2'b00};
  localparam logic [31:0] A_ME2 = {26'h0, `SFR_IDX_ENABLES_TWO, 2'b00};
  localparam logic [31:0] A_GAP = 32'h10;

  logic         hclk;
  logic         hresetn;
  logic         nmi_falling;
  logic         hsel;
  logic         hwrite;
  logic         hreadyout;
  logic         hresp;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic [5:0]   ev;
  logic [2:0]   pins;
  flags_one_t   flags_one;
  flags_two_t   flags_two;
  enables_two_t enables_two;
  int           err_total;
  int           tests_run;

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ahb_master_model i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  sfr_flags i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wdt_overflow(ev[0]), .wdt_key_violation(ev[1]), .osc_fault(ev[2]),
    .nmi_pin(pins[2]), .nmi_falling(nmi_falling), .port0_pin(pins[0]), .port1_pin(pins[1]),
    .serial_rx_done(ev[3]), .serial_tx_ready(ev[4]), .basic_timer_tick(ev[5]),
    .flags_one(flags_one), .flags_two(flags_two), .enables_two(enables_two));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] unused;
    i_host.xfer(1'b1, a, {24'h0, d}, unused);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] d;
    i_host.xfer(1'b0, a, 32'h0, d);
    check(d, {24'h0, e});
  endtask : rdchk

  task automatic conclude();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rdchk(A_F1, 8'h02);
    rdchk(A_F2, 8'h02);
    rdchk(A_ME2, 8'h00);
    check({27'h0, flags_one}, 32'h02);
    check({29'h0, flags_two}, 32'h02);
    check({31'h0, hreadyout}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  // Unmapped word and unused bit positions must read back zero
  task automatic test_access();
    logic [31:0] ad[4];
    logic [7:0]  full[4];
    ad   = '{A_F1, A_F2, A_ME2, A_GAP};
    full = '{8'h1f, 8'h83, 8'h03, 8'h00};
    for (int i = 0; i < 4; i++)
      wr(ad[i], 8'hff);
    for (int i = 0; i < 4; i++)
      rdchk(ad[i], full[i]);
    check({30'h0, enables_two}, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(ad[i], 8'h00);
      rdchk(ad[i], 8'h00);
    end
    $display("test_access done");
  endtask : test_access

  // Every hardware source sets exactly its own bit
  task automatic test_events();
    logic [31:0] ea[9];
    logic [7:0]  eb[9];
    ea = '{A_F1, A_F1, A_F1, A_F2, A_F2, A_F2, A_F1, A_F1, A_F1};
    eb = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h02, 8'h80, 8'h04, 8'h08, 8'h10};
    for (int i = 0; i < 9; i++)
    begin
      wr(A_F1, 8'h00);
      wr(A_F2, 8'h00);
      @(posedge hclk);
      if (i < 6)
      begin
        ev[i] <= 1'b1;
        @(posedge hclk);
        ev <= 6'h0;
        repeat (2) @(posedge hclk);
      end
      else
      begin
        pins[i-6] <= 1'b1;
        repeat (6) @(posedge hclk);
      end
      rdchk(ea[i], eb[i]);
      @(posedge hclk);
      pins <= 3'h0;
      repeat (6) @(posedge hclk);
    end
    nmi_falling <= 1'b1;
    pins[2]     <= 1'b1;
    repeat (6) @(posedge hclk);
    wr(A_F1, 8'h00);
    @(posedge hclk);
    pins[2] <= 1'b0;
    repeat (6) @(posedge hclk);
    rdchk(A_F1, 8'h10);
    $display("test_events done");
  endtask : test_events

  // Source held high across a clearing write
  task automatic test_priority();
    @(posedge hclk);
    ev[3] <= 1'b1;
    wr(A_F2, 8'h00);
    rdchk(A_F2, 8'h01);
    @(posedge hclk);
    ev <= 6'h0;
    wr(A_F2, 8'h00);
    rdchk(A_F2, 8'h00);
    $display("test_priority done");
  endtask : test_priority

  task automatic test_mid_reset();
    wr(A_F1, 8'h00);
    @(posedge hclk);
    ev[0] <= 1'b1;
    @(posedge hclk);
    ev <= 6'h0;
    wr(A_ME2, 8'h03);
    rdchk(A_F1, 8'h01);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(A_F1, 8'h02);
    rdchk(A_ME2, 8'h00);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total   = 0;
    tests_run   = 0;
    hresetn     = 1'b0;
    nmi_falling = 1'b0;
    ev          = 6'h0;
    pins        = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_access();
    test_events();
    test_priority();
    test_mid_reset();
    conclude();
  end

  // Whole run needs a few hundred cycles; this is far beyond
  initial
  begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : tb_special_function_flag_regs
`default_nettype wire
